/* hdl/dcmc_core.sv */
// command interpreter and monitor selection for the drive link option
// assumes commands arrive as one-cycle strobes on the drive clock
`timescale 1ns/1ns
// What this block does
// - fault-clear code with key 9696 erases all fault records at once
// - parameter-clear code with valid key restores all parameters
// - keys 9696/9966 also clear comms parameters; 5A5A/55AA keep them
// - any executed parameter clear also resets second-parameter, special and link-extended settings
// - power loss during a keeping clear still clears comms parameters
// - reset code with key 9696 performs a full drive reset
// - link-extended setting read on 7F, written on FF, selects parameter group
// - link-extended write accepted only when profile select is zero
// - calibration selector read on 6C, written on EC, values 00 to 02
// - calibration access only while link-extended setting is 1 or 9
// - two-digit writes use only the low data byte
// - 32-bit reads above 16 bits reply saturated FFFF
// - monitor select low byte feeds first result, high byte the second
// - third to sixth selectors honoured only for profiles 12, 14, 18
// - items 00, 01, 05 always report frequency regardless of display settings
// - items 00/01 frequency, 02 current, 03 voltage
// - gain frequencies also writable on codes 99 and 9A
module dcmc_core (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    input wire logic [7:0] link_profile_select_i,
    input wire logic [7:0] remote_link_ext_i,
    input wire logic clear_in_progress_i,
    input wire logic power_fail_i,
    input wire logic [15:0] monitor_select_word_i,
    input wire logic [15:0] third_monitor_select_word_i,
    input wire logic [15:0] fourth_monitor_select_word_i,
    input wire logic [15:0] fifth_monitor_select_word_i,
    input wire logic [15:0] sixth_monitor_select_word_i,
    input wire logic [31:0] out_freq_i,
    input wire logic [31:0] set_freq_i,
    input wire logic [31:0] out_current_i,
    input wire logic [31:0] out_voltage_i,
    input wire logic [31:0] other_value_i,
    output logic fault_clear_o,
    output logic param_clear_o,
    output logic comm_clear_o,
    output logic drive_reset_o,
    output logic [7:0] link_ext_o,
    output logic [7:0] calib_sel_o,
    output logic [7:0] special_sel_o,
    output logic [15:0] terminal2_gain_frequency_o,
    output logic [15:0] terminal4_gain_frequency_o,
    output logic [15:0] read_data_o,
    output logic read_valid_o,
    output logic cmd_error_o,
    output logic [15:0] first_monitor_result_o,
    output logic [15:0] second_monitor_result_o,
    output logic [15:0] third_monitor_result_o,
    output logic [15:0] fourth_monitor_result_o,
    output logic [15:0] fifth_monitor_result_o,
    output logic [15:0] sixth_monitor_result_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic fault_clear_ff;
    logic param_clear_ff;
    logic comm_clear_ff;
    logic drive_reset_ff;
    logic [7:0] link_ext_ff;
    logic [7:0] calib_ff;
    logic [7:0] special_ff;
    logic [15:0] gain2_ff;
    logic [15:0] gain4_ff;
    logic [15:0] read_data_ff;
    logic read_valid_ff;
    logic cmd_error_ff;
    logic [2:0] pf_sync_ff;
    logic pf_prev_ff;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic [7:0] low_byte;
    wire logic is_fault_clr;
    wire logic is_param_clr;
    wire logic is_reset;
    wire logic key_9696;
    wire logic key_clr_keep;
    wire logic key_all_comm;
    wire logic key_all_keep;
    wire logic do_clear;
    wire logic do_comm_clear;
    wire logic profile_plain;
    wire logic calib_ok;
    wire logic ext_write;
    wire logic calib_write;
    wire logic calib_read;
    wire logic ext_read;
    wire logic pf_level;
    wire logic pf_rise;
    wire logic known_code;
    wire logic [7:0] nxt_link_ext;
    wire logic [7:0] nxt_calib;
    wire logic [7:0] nxt_special;
    wire logic [15:0] nxt_gain2;
    wire logic [15:0] nxt_gain4;
    wire logic extra_slots;

    assign low_byte = cmd_data_i[7:0];
    assign is_fault_clr = cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_FAULT_CLEAR;
    assign is_param_clr = cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_PARAM_CLEAR;
    assign is_reset = cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_DRIVE_RESET;
    assign key_9696 = cmd_data_i == dcmc_pkg::KEY_CLEAR_COMM;
    assign key_clr_keep = cmd_data_i == dcmc_pkg::KEY_CLEAR_KEEP;
    assign key_all_comm = cmd_data_i == dcmc_pkg::KEY_ALL_COMM;
    assign key_all_keep = cmd_data_i == dcmc_pkg::KEY_ALL_KEEP;
    // unknown keys fall through and leave everything untouched
    assign do_clear = is_param_clr
                      && (key_9696 || key_clr_keep || key_all_comm || key_all_keep);
    assign do_comm_clear = is_param_clr && (key_9696 || key_all_comm);

    assign profile_plain = link_profile_select_i == dcmc_pkg::PROFILE_PLAIN;
    assign calib_ok = link_ext_ff == dcmc_pkg::LINK_EXT_CAL_A
                      || link_ext_ff == dcmc_pkg::LINK_EXT_CAL_B;
    assign ext_write = cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_LINK_EXT_WR
                       && profile_plain;
    assign ext_read = cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_LINK_EXT_RD;
    assign calib_write = cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_CALIB_WR && calib_ok
                         && low_byte <= dcmc_pkg::CALIB_MAX;
    assign calib_read = cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_CALIB_RD && calib_ok;

    // power-fail pin: three stages; the agreed level moves only when stages two and three match
    assign pf_level = (pf_sync_ff[1] == pf_sync_ff[2]) ? pf_sync_ff[2] : pf_prev_ff;
    assign pf_rise = pf_level && !pf_prev_ff;

    assign known_code = is_fault_clr || is_param_clr || is_reset || ext_read || calib_read
                        || ext_write || calib_write
                        || (cmd_valid_i && (cmd_code_i == dcmc_pkg::CODE_SPECIAL_WR
                        || cmd_code_i == dcmc_pkg::CODE_GAIN2_WR
                        || cmd_code_i == dcmc_pkg::CODE_GAIN4_WR));

    // outside profile 0 the setting follows the dedicated remote words
    assign nxt_link_ext = do_clear ? dcmc_pkg::LINK_EXT_RST
                        : !profile_plain ? remote_link_ext_i
                        : ext_write ? low_byte
                        : link_ext_ff;
    assign nxt_calib = do_clear ? dcmc_pkg::CALIB_RST
                     : calib_write ? low_byte
                     : calib_ff;
    assign nxt_special = do_clear ? dcmc_pkg::SPECIAL_RST
                       : (cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_SPECIAL_WR) ? low_byte
                       : special_ff;
    assign nxt_gain2 = do_clear ? dcmc_pkg::GAIN_RST
                     : (cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_GAIN2_WR) ? cmd_data_i
                     : gain2_ff;
    assign nxt_gain4 = do_clear ? dcmc_pkg::GAIN_RST
                     : (cmd_valid_i && cmd_code_i == dcmc_pkg::CODE_GAIN4_WR) ? cmd_data_i
                     : gain4_ff;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pf_sync_ff <= 3'h0;
            pf_prev_ff <= 1'b0;
        end else begin
            pf_sync_ff <= {pf_sync_ff[1:0], power_fail_i};
            pf_prev_ff <= pf_level;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_clear_ff <= 1'b0;
            param_clear_ff <= 1'b0;
            comm_clear_ff <= 1'b0;
            drive_reset_ff <= 1'b0;
        end else begin
            fault_clear_ff <= is_fault_clr && key_9696;
            param_clear_ff <= do_clear;
            comm_clear_ff <= do_comm_clear || (pf_rise && clear_in_progress_i);
            drive_reset_ff <= is_reset && key_9696;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link_ext_ff <= dcmc_pkg::LINK_EXT_RST;
            calib_ff <= dcmc_pkg::CALIB_RST;
            special_ff <= dcmc_pkg::SPECIAL_RST;
            gain2_ff <= dcmc_pkg::GAIN_RST;
            gain4_ff <= dcmc_pkg::GAIN_RST;
        end else begin
            link_ext_ff <= nxt_link_ext;
            calib_ff <= nxt_calib;
            special_ff <= nxt_special;
            gain2_ff <= nxt_gain2;
            gain4_ff <= nxt_gain4;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_data_ff <= 16'h0000;
            read_valid_ff <= 1'b0;
            cmd_error_ff <= 1'b0;
        end else begin
            read_valid_ff <= ext_read || calib_read;
            read_data_ff <= ext_read ? {8'h00, link_ext_ff}
                          : calib_read ? {8'h00, calib_ff}
                          : read_data_ff;
            cmd_error_ff <= cmd_valid_i && !known_code;
        end
    end

    // ------------------------------------------------------------
    // monitor slots
    // ------------------------------------------------------------
    assign extra_slots = link_profile_select_i == dcmc_pkg::PROFILE_12
                         || link_profile_select_i == dcmc_pkg::PROFILE_14
                         || link_profile_select_i == dcmc_pkg::PROFILE_18;

    wire logic [7:0] slot_item [dcmc_pkg::MON_SLOTS];
    wire logic slot_en [dcmc_pkg::MON_SLOTS];
    wire logic [15:0] slot_res [dcmc_pkg::MON_SLOTS];

    assign slot_item[0] = monitor_select_word_i[7:0];
    assign slot_item[1] = monitor_select_word_i[15:8];
    assign slot_item[2] = third_monitor_select_word_i[7:0];
    assign slot_item[3] = fourth_monitor_select_word_i[7:0];
    assign slot_item[4] = fifth_monitor_select_word_i[7:0];
    assign slot_item[5] = sixth_monitor_select_word_i[7:0];

    genvar g;
    generate
        for (g = 0; g < dcmc_pkg::MON_SLOTS; g++) begin : g_slot
            assign slot_en[g] = (g < 2) ? 1'b1 : extra_slots;
            dcmc_mon_sel u_sel (
                .clock_i(clock_i),
                .arst_n_i(arst_n_i),
                .enable_i(slot_en[g]),
                .item_i(slot_item[g]),
                .out_freq_i(out_freq_i),
                .set_freq_i(set_freq_i),
                .out_current_i(out_current_i),
                .out_voltage_i(out_voltage_i),
                .other_value_i(other_value_i),
                .result_o(slot_res[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign fault_clear_o = fault_clear_ff;
    assign param_clear_o = param_clear_ff;
    assign comm_clear_o = comm_clear_ff;
    assign drive_reset_o = drive_reset_ff;
    assign link_ext_o = link_ext_ff;
    assign calib_sel_o = calib_ff;
    assign special_sel_o = special_ff;
    assign terminal2_gain_frequency_o = gain2_ff;
    assign terminal4_gain_frequency_o = gain4_ff;
    assign read_data_o = read_data_ff;
    assign read_valid_o = read_valid_ff;
    assign cmd_error_o = cmd_error_ff;
    assign first_monitor_result_o = slot_res[0];
    assign second_monitor_result_o = slot_res[1];
    assign third_monitor_result_o = slot_res[2];
    assign fourth_monitor_result_o = slot_res[3];
    assign fifth_monitor_result_o = slot_res[4];
    assign sixth_monitor_result_o = slot_res[5];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_fault_clear: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        cmd_valid_i && cmd_code_i == 8'hF4 && cmd_data_i == 16'h9696 |=> fault_clear_o)
        else $error("fault clear missed");
    a_param_clear: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        param_clear_o |-> $past(cmd_valid_i) && $past(cmd_code_i) == 8'hFC)
        else $error("parameter clear without command");
    a_comm_keep: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        cmd_valid_i && cmd_code_i == 8'hFC && cmd_data_i == 16'h55AA && !pf_rise
        |=> param_clear_o && !comm_clear_o)
        else $error("keeping clear touched comms");
    a_clear_settings: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        do_clear |=> link_ext_o == 8'h00 && calib_sel_o == 8'h00 && special_sel_o == 8'h00)
        else $error("settings survived clear");
    a_pf_comm: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        pf_rise && clear_in_progress_i |=> comm_clear_o)
        else $error("power fail clear missed");
    a_drive_reset: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        drive_reset_o |-> $past(cmd_valid_i) && $past(cmd_code_i) == 8'hFD
        && $past(cmd_data_i) == 16'h9696)
        else $error("reset without key");
    a_ext_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        link_profile_select_i != 8'h00 |=> link_ext_o == $past(remote_link_ext_i) || param_clear_o)
        else $error("extended setting not from remote");
    a_calib_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        $changed(calib_sel_o) && !param_clear_o |-> $past(calib_ok))
        else $error("calibration changed while locked");
    a_unknown_key: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        is_param_clr && !do_clear |=> !param_clear_o)
        else $error("unknown key acted");
    a_slot_off: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !extra_slots ##1 !extra_slots |-> third_monitor_result_o == 16'h0000)
        else $error("third monitor active in wrong profile");
endmodule

/* hdl/dcmc_pkg.sv */
// constants for the drive command interpreter and monitor selector
// assumes a single clock domain; no bus, plain ports only
package dcmc_pkg;
    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_FAULT_CLEAR = 8'hF4;
    localparam logic [7:0] CODE_PARAM_CLEAR = 8'hFC;
    localparam logic [7:0] CODE_DRIVE_RESET = 8'hFD;
    localparam logic [7:0] CODE_LINK_EXT_RD = 8'h7F;
    localparam logic [7:0] CODE_LINK_EXT_WR = 8'hFF;
    localparam logic [7:0] CODE_CALIB_RD = 8'h6C;
    localparam logic [7:0] CODE_CALIB_WR = 8'hEC;
    localparam logic [7:0] CODE_SPECIAL_WR = 8'hF3;
    localparam logic [7:0] CODE_GAIN2_WR = 8'h99;
    localparam logic [7:0] CODE_GAIN4_WR = 8'h9A;
    // ------------------------------------------------------------
    // key data values and the saturated reply value
    // ------------------------------------------------------------
    localparam logic [15:0] KEY_CLEAR_COMM = 16'h9696;
    localparam logic [15:0] KEY_CLEAR_KEEP = 16'h5A5A;
    localparam logic [15:0] KEY_ALL_COMM = 16'h9966;
    localparam logic [15:0] KEY_ALL_KEEP = 16'h55AA;
    localparam logic [15:0] SATURATED = 16'hFFFF;
    // ------------------------------------------------------------
    // selector values and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CALIB_MAX = 8'h02;
    localparam logic [7:0] LINK_EXT_CAL_A = 8'h01;
    localparam logic [7:0] LINK_EXT_CAL_B = 8'h09;
    localparam logic [7:0] LINK_EXT_RST = 8'h00;
    localparam logic [7:0] CALIB_RST = 8'h00;
    localparam logic [7:0] SPECIAL_RST = 8'h00;
    localparam logic [15:0] GAIN_RST = 16'h0000;
    localparam logic [7:0] PROFILE_PLAIN = 8'h00;
    localparam logic [7:0] PROFILE_12 = 8'h0C;
    localparam logic [7:0] PROFILE_14 = 8'h0E;
    localparam logic [7:0] PROFILE_18 = 8'h12;
    // ------------------------------------------------------------
    // monitor item codes and slot count
    // ------------------------------------------------------------
    localparam logic [7:0] MON_FREQ_A = 8'h00;
    localparam logic [7:0] MON_FREQ_B = 8'h01;
    localparam logic [7:0] MON_CURRENT = 8'h02;
    localparam logic [7:0] MON_VOLTAGE = 8'h03;
    localparam logic [7:0] MON_SET_FREQ = 8'h05;
    localparam int MON_SLOTS = 6;
endpackage

/* hdl/dcmc_mon_sel.sv */
// one monitor slot: picks a value by item code, saturates 32-bit values
// assumes the drive supplies values already scaled to their units
`timescale 1ns/1ns
module dcmc_mon_sel (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic enable_i,
    input wire logic [7:0] item_i,
    input wire logic [31:0] out_freq_i,
    input wire logic [31:0] set_freq_i,
    input wire logic [31:0] out_current_i,
    input wire logic [31:0] out_voltage_i,
    input wire logic [31:0] other_value_i,
    output logic [15:0] result_o
);
    logic [15:0] result_ff;
    wire logic [31:0] picked;
    wire logic [15:0] nxt_result;

    // frequency items ignore display scaling: raw 0.01 Hz values
    assign picked = (item_i == dcmc_pkg::MON_FREQ_A || item_i == dcmc_pkg::MON_FREQ_B)
                    ? out_freq_i
                  : (item_i == dcmc_pkg::MON_SET_FREQ) ? set_freq_i
                  : (item_i == dcmc_pkg::MON_CURRENT) ? out_current_i
                  : (item_i == dcmc_pkg::MON_VOLTAGE) ? out_voltage_i
                  : other_value_i;
    assign nxt_result = !enable_i ? 16'h0000
                      : (picked[31:16] != 16'h0000) ? dcmc_pkg::SATURATED
                      : picked[15:0];

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_ff <= 16'h0000;
        end else begin
            result_ff <= nxt_result;
        end
    end
    assign result_o = result_ff;

    a_mon_saturate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        enable_i && picked[31:16] != 16'h0000 |=> result_o == 16'hFFFF)
        else $error("monitor value not saturated");
endmodule

/* testbench/dcmc_drive_model.sv */
// drive-side model: fixed drive values and a keeping clear that runs a while
// assumes the interpreter's clear pulses last one clock cycle
`timescale 1ns/1ns
module dcmc_drive_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic param_clear_i,
    input wire logic comm_clear_i,
    output logic clear_in_progress_o,
    output logic [31:0] out_freq_o,
    output logic [31:0] set_freq_o,
    output logic [31:0] out_current_o,
    output logic [31:0] out_voltage_o,
    output logic [31:0] other_value_o
);
    logic [4:0] busy_cnt_ff;
    assign clear_in_progress_o = (busy_cnt_ff != 5'h00);
    assign out_freq_o = 32'h0000_1388;
    assign set_freq_o = 32'h0000_0BB8;
    assign out_current_o = 32'h0000_0064;
    assign out_voltage_o = 32'h0000_0DC0;
    // wider than 16 bits on purpose
    assign other_value_o = 32'h0001_2345;
    // a clear that keeps comms parameters stays busy for 31 cycles
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_cnt_ff <= 5'h00;
        end else if (param_clear_i && !comm_clear_i) begin
            busy_cnt_ff <= 5'h1F;
        end else if (busy_cnt_ff != 5'h00) begin
            busy_cnt_ff <= busy_cnt_ff - 5'h01;
        end
    end
endmodule

/* testbench/drive_command_and_monitor_codes_tb_top.sv */
// self-checking bench for the command interpreter and monitor selector
// assumes the drive model supplies drive values and clear progress
`timescale 1ns/1ns
module drive_command_and_monitor_codes_tb_top;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic power_fail_i = 1'b0;
    logic [7:0] cmd_code_i = 8'h00;
    logic [15:0] cmd_data_i = 16'h0000;
    logic [7:0] link_profile_select_i = 8'h00;
    logic [7:0] remote_link_ext_i = 8'h00;
    logic [15:0] monitor_select_word_i = 16'h0000;
    logic [15:0] third_monitor_select_word_i = 16'h0003;
    logic [15:0] fourth_monitor_select_word_i = 16'h0005;
    logic [15:0] fifth_monitor_select_word_i = 16'h0001;
    logic [15:0] sixth_monitor_select_word_i = 16'h0000;
    logic clear_in_progress_i;
    logic [31:0] out_freq_i, set_freq_i, out_current_i, out_voltage_i, other_value_i;
    logic fault_clear_o, param_clear_o, comm_clear_o, drive_reset_o, read_valid_o, cmd_error_o;
    logic [7:0] link_ext_o, calib_sel_o, special_sel_o;
    logic [15:0] terminal2_gain_frequency_o, terminal4_gain_frequency_o, read_data_o;
    logic [15:0] first_monitor_result_o, second_monitor_result_o, third_monitor_result_o;
    logic [15:0] fourth_monitor_result_o, fifth_monitor_result_o, sixth_monitor_result_o;
    logic [7:0] prof [5] = '{8'h0C, 8'h0E, 8'h12, 8'h00, 8'h07};
    logic [15:0] m;
    int err_count = 0;
    int n_tests = 0;
    int i;
    always #20 clock_i = ~clock_i;
    dcmc_core i_dut (
        .clock_i, .arst_n_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i,
        .link_profile_select_i, .remote_link_ext_i, .clear_in_progress_i, .power_fail_i,
        .monitor_select_word_i, .third_monitor_select_word_i,
        .fourth_monitor_select_word_i, .fifth_monitor_select_word_i,
        .sixth_monitor_select_word_i, .out_freq_i, .set_freq_i, .out_current_i,
        .out_voltage_i, .other_value_i, .fault_clear_o, .param_clear_o, .comm_clear_o,
        .drive_reset_o, .link_ext_o, .calib_sel_o, .special_sel_o,
        .terminal2_gain_frequency_o, .terminal4_gain_frequency_o, .read_data_o,
        .read_valid_o, .cmd_error_o, .first_monitor_result_o, .second_monitor_result_o,
        .third_monitor_result_o, .fourth_monitor_result_o, .fifth_monitor_result_o,
        .sixth_monitor_result_o
    );
    dcmc_drive_model i_drive (
        .clock_i, .arst_n_i, .param_clear_i(param_clear_o), .comm_clear_i(comm_clear_o),
        .clear_in_progress_o(clear_in_progress_i), .out_freq_o(out_freq_i),
        .set_freq_o(set_freq_i), .out_current_o(out_current_i),
        .out_voltage_o(out_voltage_i), .other_value_o(other_value_i)
    );
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one strobe, then the pulses {fault,param,comm,reset,read,error}
    task automatic cmd(input logic [7:0] code, input logic [15:0] data, input logic [5:0] p);
        @(negedge clock_i);
        cmd_valid_i = 1'b1;
        cmd_code_i = code;
        cmd_data_i = data;
        @(negedge clock_i);
        cmd_valid_i = 1'b0;
        chk({10'h000, fault_clear_o, param_clear_o, comm_clear_o, drive_reset_o,
             read_valid_o, cmd_error_o}, {10'h000, p});
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clock_i);
        arst_n_i = 1'b1;
        chk({link_ext_o, calib_sel_o}, 16'h0000);
        cmd(8'hFF, 16'hAB01, 6'h00);
        cmd(8'h7F, 16'h0000, 6'h02);
        chk(read_data_o, 16'h0001);
        cmd(8'hEC, 16'h5502, 6'h00);
        cmd(8'hEC, 16'h0003, 6'h01);
        cmd(8'h6C, 16'h0000, 6'h02);
        chk(read_data_o, 16'h0002);
        cmd(8'hF3, 16'h0005, 6'h00);
        cmd(8'h99, 16'h1234, 6'h00);
        cmd(8'h9A, 16'h5678, 6'h00);
        chk(terminal2_gain_frequency_o, 16'h1234);
        chk(terminal4_gain_frequency_o, 16'h5678);
        cmd(8'hFC, 16'h1234, 6'h00);
        cmd(8'hF4, 16'h9966, 6'h00);
        cmd(8'hFD, 16'h5A5A, 6'h00);
        chk({link_ext_o, calib_sel_o}, 16'h0102);
        chk({8'h00, special_sel_o}, 16'h0005);
        cmd(8'hF4, 16'h9696, 6'h20);
        cmd(8'hFD, 16'h9696, 6'h04);
        cmd(8'hFC, 16'h9696, 6'h18);
        chk({link_ext_o, calib_sel_o}, 16'h0000);
        chk({8'h00, special_sel_o}, 16'h0000);
        chk(terminal2_gain_frequency_o, 16'h0000);
        cmd(8'hFC, 16'h9966, 6'h18);
        cmd(8'hFC, 16'h5A5A, 6'h10);
        cmd(8'hFC, 16'h55AA, 6'h10);
        // power lost while the keeping clear is still running
        power_fail_i = 1'b1;
        for (i = 0; i < 10 && comm_clear_o !== 1'b1; i++) begin
            @(negedge clock_i);
        end
        chk({15'h0000, comm_clear_o}, 16'h0001);
        if (i == 10) results();
        power_fail_i = 1'b0;
        cmd(8'hEC, 16'h0001, 6'h01);
        cmd(8'hFF, 16'h0009, 6'h00);
        cmd(8'hEC, 16'h0001, 6'h00);
        cmd(8'hFF, 16'h0005, 6'h00);
        cmd(8'h6C, 16'h0000, 6'h01);
        chk({8'h00, calib_sel_o}, 16'h0001);
        link_profile_select_i = 8'h0C;
        remote_link_ext_i = 8'h09;
        cmd(8'hFF, 16'h0001, 6'h01);
        chk({8'h00, link_ext_o}, 16'h0009);
        monitor_select_word_i = 16'h0602;
        for (i = 0; i < 5; i++) begin
            link_profile_select_i = prof[i];
            m = (i < 3) ? 16'hFFFF : 16'h0000;
            repeat (2) @(negedge clock_i);
            chk(first_monitor_result_o, out_current_i[15:0]);
            chk(second_monitor_result_o, 16'hFFFF);
            chk(third_monitor_result_o, out_voltage_i[15:0] & m);
            chk(fourth_monitor_result_o, set_freq_i[15:0] & m);
            chk(fifth_monitor_result_o, out_freq_i[15:0] & m);
            chk(sixth_monitor_result_o, out_freq_i[15:0] & m);
        end
        monitor_select_word_i = 16'h0100;
        repeat (2) @(negedge clock_i);
        chk(first_monitor_result_o, out_freq_i[15:0]);
        chk(second_monitor_result_o, out_freq_i[15:0]);
        results();
    end
endmodule
